// [hdl/misc_ctrl_regs.svh]
// Constants of the reset, serial ROM and test status control block
`ifndef MISC_CTRL_REGS_SVH
`define MISC_CTRL_REGS_SVH

// ****************************************************************
// Timing counts
// ****************************************************************
`define SERIAL_CONFIG_ROM_DIV_CYCLES        256
`define SERIAL_CONFIG_ROM_RISE_PHASE        8'h80
`define SERIAL_CONFIG_ROM_SAMPLE_PHASE      8'h00
`define TIMEOUT_CYCLES_DEFAULT 1000000000
`define TIMEOUT_CNT_W          30
`define TIMEOUT_PULSE_CYCLES   9'h100

// ****************************************************************
// Field widths and reset values
// ****************************************************************
`define SERIAL_CONFIG_ROM_LOAD_BITS         6'h20
`define SERIAL_CONFIG_ROM_LOAD_W            32
`define TEST_STATUS_RST        1'b0
`define SERIAL_CONFIG_ROM_OE_N_RST          1'b1

`endif

// [hdl/misc_ctrl_pkg.sv]
// Types shared by the reset, serial ROM and test status control block
package misc_ctrl_pkg;

    typedef enum logic [2:0] {
        phase_hold,
        phase_serial_config_rom_load,
        phase_bist_start,
        phase_bist_wait,
        phase_run
    } phase_type;

    // Pins toward the serial configuration ROM
    typedef struct packed {
        logic serial_rom_clock_out;
        logic serial_rom_output_enable_n;
    } serial_config_rom_pins_type;

    // Cache self-test answer from the core
    typedef struct packed {
        logic done;
        logic pass;
    } bist_resp_type;

    typedef struct packed {
        logic [7:0] phase_cnt;
        logic       rom_clock;
    } div_state_type;

    typedef struct packed {
        logic        bypass_meta;
        logic        bypass_sync;
        logic        rstn_meta;
        logic        rstn_sync;
        logic        pgood_meta;
        logic        pgood_sync;
        logic        pgood_seen;
        logic        data_meta;
        logic        data_sync;
        phase_type   phase;
        logic [5:0]  bits_left;
        logic [31:0] load_buf;
        logic        load_done;
        logic        seq_start;
        logic        bist_start;
        logic        bist_fail;
        logic        test_status;
        logic [29:0] retire_cnt;
        logic [8:0]  pulse_cnt;
        logic        timeout_reset;
        logic        oe_n;
    } ctrl_state_type;

endpackage

// [hdl/serial_config_rom_clock_div.sv]
// Serial ROM clock divider with advance and sample strobes
`include "misc_ctrl_regs.svh"

module serial_config_rom_clock_div
(
    // Clock and reset
    input  wire logic clock,
    input  wire logic rst,
    // Control
    input  wire logic enable,
    // Outputs
    output logic      rom_clock,
    output logic      advance_pulse,
    output logic      sample_pulse
);
    import misc_ctrl_pkg::*;

    div_state_type state_reg;
    div_state_type state_next;

    always_comb
    begin
        state_next = state_reg;
        if (!enable)
        begin
            // Idle low so the ROM sees no stray edge outside a load
            state_next.phase_cnt = 8'h00;
            state_next.rom_clock = 1'b0;
        end
        else
        begin
            // Eight-bit wrap gives the full division period
            state_next.phase_cnt = state_reg.phase_cnt + 8'h01;
            state_next.rom_clock = (state_next.phase_cnt >= `SERIAL_CONFIG_ROM_RISE_PHASE);
        end
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            state_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign rom_clock     = state_reg.rom_clock;
    // ROM advances one bit on each rising edge of its clock
    assign advance_pulse = enable && (state_reg.phase_cnt == `SERIAL_CONFIG_ROM_RISE_PHASE);
    // Half a period after the rise, the ROM output has long settled
    assign sample_pulse  = enable && state_reg.rom_clock
                           && (state_next.phase_cnt == `SERIAL_CONFIG_ROM_SAMPLE_PHASE);

endmodule

// [hdl/reset_serial_config_rom_test_status_ctrl.sv]
// Reset hold-off, serial ROM load, self-test status and retirement timeout control
`include "misc_ctrl_regs.svh"

module reset_serial_config_rom_test_status_ctrl
#(
    parameter int unsigned TIMEOUT_CYCLES = `TIMEOUT_CYCLES_DEFAULT
)
(
    // Clock and reset
    input  wire logic                          clock,
    input  wire logic                          rst,
    // Board pins
    input  wire logic                          clock_bypass_select,
    input  wire logic                          system_reset_n,
    input  wire logic                          power_good_in,
    // Serial configuration ROM pins
    input  wire logic                          serial_rom_data_in,
    output misc_ctrl_pkg::serial_config_rom_pins_type       serial_config_rom_pins,
    // Test status pin
    output logic                               test_status_out,
    // Core side
    input  wire misc_ctrl_pkg::bist_resp_type  bist_resp,
    input  wire logic                          instr_retired,
    output logic                               clock_bypass_active,
    output logic                               reset_sequence_start,
    output logic                               bist_start,
    output logic [`SERIAL_CONFIG_ROM_LOAD_W-1:0]            serial_config_rom_load_data,
    output logic                               serial_config_rom_load_done,
    output logic                               timeout_reset
);
    import misc_ctrl_pkg::*;

    // Compared against a fixed last value, so any limit costs one comparator
    localparam logic [`TIMEOUT_CNT_W-1:0] TIMEOUT_LAST =
        `TIMEOUT_CNT_W'(TIMEOUT_CYCLES - 1);

    ctrl_state_type state_reg;
    ctrl_state_type state_next;

    logic rom_clock;
    logic advance_pulse;
    logic sample_pulse;
    logic divider_enable;

    // ****************************************************************
    // Serial ROM clock
    // ****************************************************************
    assign divider_enable = (state_reg.phase == phase_serial_config_rom_load);

    // The advance strobe stays unused: the ROM steps on its own clock edge
    serial_config_rom_clock_div u_serial_config_rom_clock_div
    (
        .clock         (clock),
        .rst           (rst),
        .enable        (divider_enable),
        .rom_clock     (rom_clock),
        .advance_pulse (),
        .sample_pulse  (sample_pulse)
    );

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb
    begin
        state_next = state_reg;

        // ****************************************************************
        // Pin synchronisers
        // ****************************************************************
        // First stages feed only the second, never the logic
        state_next.bypass_meta = clock_bypass_select;
        state_next.bypass_sync = state_reg.bypass_meta;
        state_next.rstn_meta   = system_reset_n;
        state_next.rstn_sync   = state_reg.rstn_meta;
        state_next.pgood_meta  = power_good_in;
        state_next.pgood_sync  = state_reg.pgood_meta;
        state_next.data_meta   = serial_rom_data_in;
        state_next.data_sync   = state_reg.data_meta;

        state_next.seq_start     = 1'b0;
        state_next.bist_start    = 1'b0;
        state_next.timeout_reset = 1'b0;

        // ****************************************************************
        // Phase sequencing
        // ****************************************************************
        if (!state_reg.rstn_sync)
        begin
            // Board holds reset; nothing starts until it lets go
            state_next.phase       = phase_hold;
            state_next.test_status = 1'b0;
            state_next.pulse_cnt   = 9'h000;
            state_next.retire_cnt  = '0;
            state_next.oe_n        = 1'b1;
            state_next.load_done   = 1'b0;
            // The load buffer keeps its last word until the next load overwrites it
            // Power good only counts if seen while reset is held
            state_next.pgood_seen  = state_reg.pgood_sync;
        end
        else
        begin
            case (state_reg.phase)
                phase_hold:
                begin
                    // A release without power good is not trusted
                    if (state_reg.pgood_seen)
                    begin
                        state_next.seq_start = 1'b1;
                        state_next.phase     = phase_serial_config_rom_load;
                        state_next.bits_left = `SERIAL_CONFIG_ROM_LOAD_BITS;
                        state_next.oe_n      = 1'b0;
                    end
                end
                phase_serial_config_rom_load:
                begin
                    if (sample_pulse)
                    begin
                        state_next.load_buf  = {state_reg.load_buf[30:0],
                                                state_reg.data_sync};
                        state_next.bits_left = state_reg.bits_left - 6'h01;
                        // The last shift and the disable land on one edge
                        if (state_reg.bits_left == 6'h01)
                        begin
                            state_next.load_done = 1'b1;
                            state_next.oe_n      = 1'b1;
                            state_next.phase     = phase_bist_start;
                        end
                    end
                end
                phase_bist_start:
                begin
                    // Status rises on the same edge as the start strobe
                    state_next.bist_start  = 1'b1;
                    state_next.test_status = 1'b1;
                    state_next.phase       = phase_bist_wait;
                end
                phase_bist_wait:
                begin
                    if (bist_resp.done)
                    begin
                        // A failing test leaves the pin high until the board next holds reset
                        state_next.bist_fail   = !bist_resp.pass;
                        state_next.test_status = !bist_resp.pass;
                        state_next.phase       = phase_run;
                        // The first timeout window starts clean at the run phase
                        state_next.retire_cnt  = '0;
                    end
                end
                phase_run:
                begin
                    // A retirement in the cycle of the limit wins and restarts the count
                    if (instr_retired)
                    begin
                        state_next.retire_cnt = '0;
                    end
                    else if (state_reg.retire_cnt == TIMEOUT_LAST)
                    begin
                        state_next.retire_cnt    = '0;
                        state_next.timeout_reset = 1'b1;
                        state_next.pulse_cnt     = `TIMEOUT_PULSE_CYCLES;
                        state_next.test_status   = 1'b1;
                    end
                    else
                    begin
                        state_next.retire_cnt = state_reg.retire_cnt + 30'h0000_0001;
                    end

                    // ****************************************************************
                    // Timeout pulse
                    // ****************************************************************
                    // A timeout inside the pulse keeps the reload and restarts the width
                    if (!state_next.timeout_reset && state_reg.pulse_cnt != 9'h000)
                    begin
                        // Counter loaded with the full width; pin falls after it if the self-test passed
                        state_next.pulse_cnt = state_reg.pulse_cnt - 9'h001;
                        if (state_reg.pulse_cnt == 9'h001)
                        begin
                            // Pin returns to the self-test verdict
                            state_next.test_status = state_reg.bist_fail;
                        end
                    end
                end
                default:
                begin
                    state_next.phase = phase_hold;
                end
            endcase
        end
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            // Reset leaves the ROM disabled and the status pin low
            state_reg             <= '0;
            state_reg.phase       <= phase_hold;
            state_reg.test_status <= `TEST_STATUS_RST;
            state_reg.oe_n        <= `SERIAL_CONFIG_ROM_OE_N_RST;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    // Clock muxing is done in the clock tree; this flag steers it
    assign clock_bypass_active = state_reg.bypass_sync;
    assign serial_config_rom_pins.serial_rom_clock_out       = rom_clock;
    assign serial_config_rom_pins.serial_rom_output_enable_n = state_reg.oe_n;
    // Every pin and pulse comes straight from a flip-flop, so none can glitch
    assign test_status_out      = state_reg.test_status;
    assign reset_sequence_start = state_reg.seq_start;
    assign bist_start           = state_reg.bist_start;
    assign serial_config_rom_load_data       = state_reg.load_buf;
    assign serial_config_rom_load_done       = state_reg.load_done;
    assign timeout_reset        = state_reg.timeout_reset;

endmodule

// [testbench/misc_ctrl_props.sv]
// Checker for the reset, serial ROM and test status control block
module misc_ctrl_props
#(
    parameter int unsigned TIMEOUT_CYCLES = 1000000000
)
(
    // Watched ports
    input wire logic                         clock,
    input wire logic                         rst,
    input wire logic                         clock_bypass_select,
    input wire logic                         system_reset_n,
    input wire logic                         instr_retired,
    input wire misc_ctrl_pkg::serial_config_rom_pins_type serial_config_rom_pins,
    input wire logic                         test_status_out,
    input wire misc_ctrl_pkg::bist_resp_type bist_resp,
    input wire logic                         clock_bypass_active,
    input wire logic                         reset_sequence_start,
    input wire logic                         bist_start,
    input wire logic                         serial_config_rom_load_done,
    input wire logic                         timeout_reset
);
    import misc_ctrl_pkg::*;
    logic [31:0] idle_cnt;
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    // Counts from before the run phase, so it can only lead the design's own count;
    // when the timeout pulse is seen, one idle cycle has already passed
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            idle_cnt <= 32'h0000_0000;
        else if (instr_retired)
            idle_cnt <= 32'h0000_0000;
        else if (timeout_reset)
            idle_cnt <= 32'h0000_0001;
        else
            idle_cnt <= idle_cnt + 32'h0000_0001;
    end
    a_bypass_follow : assert property (
        !$past(rst) && !$past(rst, 2) |-> clock_bypass_active == $past(clock_bypass_select, 2))
        else $error("bypass flag does not follow its pin");
    a_start_released : assert property (
        reset_sequence_start |-> $past(system_reset_n, 3))
        else $error("reset sequence started while reset held");
    a_clock_high_half : assert property (
        $rose(serial_config_rom_pins.serial_rom_clock_out) |-> ##128 $fell(serial_config_rom_pins.serial_rom_clock_out))
        else $error("rom clock high phase wrong");
    a_clock_low_half : assert property (
        $fell(serial_config_rom_pins.serial_rom_clock_out)
        |-> ##128 ($rose(serial_config_rom_pins.serial_rom_clock_out) || serial_config_rom_load_done))
        else $error("rom clock low phase wrong");
    a_enable_on_start : assert property (
        reset_sequence_start |-> !serial_config_rom_pins.serial_rom_output_enable_n)
        else $error("rom not enabled at sequence start");
    a_enable_off_done : assert property (
        serial_config_rom_load_done |-> serial_config_rom_pins.serial_rom_output_enable_n)
        else $error("rom still enabled after load");
    a_status_in_reset : assert property (
        !$past(system_reset_n, 3) |-> !test_status_out)
        else $error("status high during system reset");
    a_bist_begin : assert property (
        $rose(serial_config_rom_load_done) |=> bist_start && test_status_out)
        else $error("self-test start not flagged on status");
    a_timeout_wait : assert property (
        timeout_reset |-> idle_cnt >= TIMEOUT_CYCLES)
        else $error("timeout came too early");
    a_pulse_width : assert property (
        $fell(test_status_out) && $past(system_reset_n, 2)
        && !(bist_resp.done || $past(bist_resp.done)) |-> $past(timeout_reset, 256))
        else $error("timeout pulse width wrong");
endmodule

bind reset_serial_config_rom_test_status_ctrl misc_ctrl_props #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) props_i (
    .clock(clock), .rst(rst), .clock_bypass_select(clock_bypass_select),
    .system_reset_n(system_reset_n), .instr_retired(instr_retired), .serial_config_rom_pins(serial_config_rom_pins),
    .test_status_out(test_status_out), .bist_resp(bist_resp),
    .clock_bypass_active(clock_bypass_active), .reset_sequence_start(reset_sequence_start),
    .bist_start(bist_start), .serial_config_rom_load_done(serial_config_rom_load_done), .timeout_reset(timeout_reset));

// [testbench/rom_model.sv]
// Behavioural serial configuration ROM
module rom_model
(
    // ROM pins
    input  wire logic        rom_clock,
    input  wire logic        oe_n,
    output logic             data_out,
    // Stored word, first bit in bit 31
    input  wire logic [31:0] contents
);
    timeunit 1ns;
    timeprecision 1ps;
    int idx;
    initial
    begin
        idx = 0;
        data_out = 1'b1;
    end
    // A released line shows the inverse of its last value, never a held bit
    always @(negedge oe_n)
    begin
        idx = 0;
        data_out = ~data_out;
    end
    always @(posedge oe_n) data_out = ~data_out;
    always @(posedge rom_clock)
    begin
        if (!oe_n && idx < 32)
        begin
            data_out = contents[31 - idx];
            idx = idx + 1;
        end
    end
endmodule

// [testbench/tb_top.sv]
// Self-checking bench of the reset, serial ROM and test status control block
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import misc_ctrl_pkg::*;
    logic clock = 1'b0;
    logic rst, clock_bypass_select, system_reset_n, power_good_in, rom_data;
    logic [1:0] bp_hist;
    logic instr_retired, clock_bypass_active, reset_sequence_start, bist_start;
    logic test_status_out, load_done, timeout_reset, early, pass_bit;
    serial_config_rom_pins_type rom_pins;
    bist_resp_type bist_resp;
    logic [31:0] load_data, word;
    int error_cnt, compares, n, seed;
    reset_serial_config_rom_test_status_ctrl #(.TIMEOUT_CYCLES(300)) reset_serial_config_rom_test_status_ctrl_i (
        .clock(clock), .rst(rst), .clock_bypass_select(clock_bypass_select),
        .system_reset_n(system_reset_n), .power_good_in(power_good_in),
        .serial_rom_data_in(rom_data), .serial_config_rom_pins(rom_pins), .test_status_out(test_status_out),
        .bist_resp(bist_resp), .instr_retired(instr_retired),
        .clock_bypass_active(clock_bypass_active), .reset_sequence_start(reset_sequence_start),
        .bist_start(bist_start), .serial_config_rom_load_data(load_data), .serial_config_rom_load_done(load_done),
        .timeout_reset(timeout_reset));
    rom_model rom_model_i (.rom_clock(rom_pins.serial_rom_clock_out),
        .oe_n(rom_pins.serial_rom_output_enable_n), .data_out(rom_data), .contents(word));
    // ****************************************************************
    // Checking and closing
    // ****************************************************************
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic results();
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // ****************************************************************
    // Stimulus
    // ****************************************************************
    initial
    begin
        forever #12.5 clock = ~clock;
    end
    always @(negedge clock) clock_bypass_select <= 1'($random(seed));
    // Bypass pin as the design's clock edges see it, two edges deep
    always @(posedge clock) bp_hist <= {bp_hist[0], clock_bypass_select};
    initial
    begin
        #1_500_000;
        error_cnt++;
        $display("Watchdog ran out");
        results();
    end
    initial
    begin
        seed = 64809;
        {rst, system_reset_n, power_good_in, instr_retired, clock_bypass_select} = 5'h10;
        bist_resp = '0;
        word = $random(seed);
        error_cnt = 0;
        compares = 0;
        repeat (2) @(negedge clock);
        rst = 1'b0;
        for (int run = 0; run < 3; run++)
        begin
            // The middle run fails, so the last one enters reset with the pin high
            pass_bit = (run != 1);
            word = $random(seed);
            system_reset_n = 1'b0;
            power_good_in = 1'b0;
            repeat (4) @(negedge clock);
            check("status_in_reset", test_status_out, 0);
            power_good_in = 1'b1;
            repeat (4) @(negedge clock);
            check("start_while_held", reset_sequence_start, 0);
            system_reset_n = 1'b1;
            for (n = 0; reset_sequence_start !== 1'b1 && n < 10; n++) @(negedge clock);
            check("sequence_start", reset_sequence_start, 1);
            check("rom_enable", rom_pins.serial_rom_output_enable_n, 0);
            check("bypass_flag", clock_bypass_active, bp_hist[1]);
            for (n = 0; load_done !== 1'b1 && n < 9000; n++) @(negedge clock);
            check("load_done", load_done, 1);
            check("rom_disable", rom_pins.serial_rom_output_enable_n, 1);
            check("load_word", load_data, word);
            @(negedge clock);
            check("bist_start", bist_start, 1);
            check("status_bist", test_status_out, 1);
            repeat (1 + ($random(seed) & 7)) @(negedge clock);
            bist_resp = {1'b1, pass_bit};
            @(negedge clock);
            bist_resp = '0;
            @(negedge clock);
            check("status_result", test_status_out, !pass_bit);
            early = 1'b0;
            repeat (400)
            begin
                instr_retired = ($random(seed) & 3) != 0;
                @(negedge clock);
                early = early | timeout_reset;
            end
            check("no_timeout", early, 0);
            instr_retired = 1'b0;
            for (n = 0; timeout_reset !== 1'b1 && n < 400; n++) @(negedge clock);
            check("timeout_seen", timeout_reset, 1);
            for (n = 0; test_status_out === 1'b1 && n < 600; n++) @(negedge clock);
            check("pulse_cycles", n, pass_bit ? 256 : 600);
            $display("run %0d done", run);
        end
        results();
    end
endmodule
